/* verilog/hsc_regs.svh */
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH
// How it works
// - Halt instruction pulse puts the core in standby
// - Pending unmasked request at entry wakes at once
// - Core clock gated off while in standby
// - Port output latches frozen during standby
// - 16-bit timer and prescaled timer B keep running
// - Timer B on slow oscillator runs unless stopped
// - Watchdog on system clock halts; refused if fixed
// - Watchdog on slow oscillator follows oscillator state
// - Unmasked interrupt request releases standby
// - Release with global enable set gives vectoring
// - Release with global enable clear resumes next instruction
// - Vectored release waits eleven to thirteen clocks
// - Plain release waits three to five clocks
// - Reset releases standby and restarts at reset vector
// - Hold after reset while option configuration loads

////////////////////////////////////////////////////////////////////////////////
// Clock and timing
`define HSC_CLK_MHZ         25
`define HSC_OPT_READ_NS     544000
`define HSC_OPT_READ_MAX_NS 1074000
`define HSC_OPT_READ_CYC    ((`HSC_OPT_READ_NS * `HSC_CLK_MHZ + 999) / 1000)
`define HSC_OPT_MAX_CYC     ((`HSC_OPT_READ_MAX_NS * `HSC_CLK_MHZ) / 1000)
`define HSC_WAKE_VEC_MIN    11
`define HSC_WAKE_VEC_MAX    13
`define HSC_WAKE_VEC_CYC    12
`define HSC_WAKE_PLAIN_MIN  3
`define HSC_WAKE_PLAIN_MAX  5
`define HSC_WAKE_PLAIN_CYC  4

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define HSC_OFS_CTRL   4'h0
`define HSC_OFS_STATUS 4'h4
`define HSC_OFS_PEND   4'h8

// Control register fields
`define HSC_CTRL_LSOSC_STOP 0
`define HSC_CTRL_WDT_SYS    1
`define HSC_CTRL_TMB_LS     2
`define HSC_CTRL_TM16_ON    3
`define HSC_CTRL_TMB_ON     4
`define HSC_CTRL_WDT_ON     5
`define HSC_CTRL_W          6
`define HSC_CTRL_RST        6'h20

// Status register fields
`define HSC_ST_STATE_LO    0
`define HSC_ST_UNSTOP      2
`define HSC_ST_LAST_VEC    3
`define HSC_ST_WAKE_IRQ    4
`define HSC_ST_WDT_REFUSED 5
`endif

/* verilog/hsc_pkg.sv */
package hsc_pkg;
  typedef enum logic [1:0] {
    HSC_OPT  = 2'b00,
    HSC_RUN  = 2'b01,
    HSC_HALT = 2'b11,
    HSC_WAKE = 2'b10
  } hsc_state_e;

  typedef struct packed {
    hsc_state_e  st;
    logic [15:0] opt_cnt;
    logic        unstop;
    logic [5:0]  ctrl;
    logic        last_vec;
    logic        wake_irq;
    logic        wdt_refused;
    logic        pend_vec;
    logic        ack;
    logic [31:0] rdata;
    logic        cpu_clk_en;
    logic        rst_vec;
    logic        vec_req;
    logic        resume;
    logic        halted;
    logic        port_en;
    logic        lsosc_en;
    logic        tm16_en;
    logic        tmb_en;
    logic        wdt_en;
    logic        aux_en;
  } hsc_top_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic       done;
  } hsc_wake_s;
endpackage

/* verilog/hsc_sync2.sv */
`timescale 1ns/1ps
module hsc_sync2 #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } hsc_sync_s;

  hsc_sync_s s_ff;
  hsc_sync_s nxt_s;

  if (W < 1) begin : g_chk
    $error("hsc_sync2: width must be at least one");
  end

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = d_i;
    nxt_s.sync = s_ff.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q_o = s_ff.sync;
endmodule // hsc_sync2

/* verilog/hsc_wake_timer.sv */
`timescale 1ns/1ps
module hsc_wake_timer
  import hsc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [3:0] load_i,
  output logic            done_o
);
  import hsc_pkg::*;

  hsc_wake_s s_ff;
  hsc_wake_s nxt_s;

  // Counts load_i cycles after start, then pulses done
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (start_i) begin
      nxt_s.cnt = load_i - 4'h1;
    end else if (s_ff.cnt != 4'h0) begin
      nxt_s.cnt = s_ff.cnt - 4'h1;
      nxt_s.done = (s_ff.cnt == 4'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '{cnt: 4'h0, done: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done_o = s_ff.done;
endmodule // hsc_wake_timer

/* verilog/hsc_top.sv */
`timescale 1ns/1ps
`include "hsc_regs.svh"
module hsc_top #(
  parameter int IRQ_N           = 8,
  parameter int OPT_READ_CYCLES = `HSC_OPT_READ_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // CPU core and interrupt logic
  input  wire logic             halt_exec_i,
  input  wire logic [IRQ_N-1:0] irq_req_i,
  input  wire logic [IRQ_N-1:0] interrupt_mask_flag_i,
  input  wire logic             global_interrupt_enable_i,
  // Pins
  input  wire logic             reset_pin_n_i,
  input  wire logic             opt_lsosc_fixed_i,
  // Clock gating and peripheral enables
  output logic                  cpu_clk_en_o,
  output logic                  reset_vector_o,
  output logic                  vector_req_o,
  output logic                  resume_next_o,
  output logic                  halted_o,
  output logic                  port_latch_en_o,
  output logic                  lsosc_en_o,
  output logic                  tm16_en_o,
  output logic                  eight_bit_timer_b_en_o,
  output logic                  wdt_en_o,
  output logic                  poc_en_o,
  output logic                  lvd_en_o,
  output logic                  extint_en_o
);
  import hsc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (IRQ_N < 1 || IRQ_N > 32) begin : g_chk_irq
    $error("hsc_top: IRQ_N must lie between 1 and 32");
  end
  if (OPT_READ_CYCLES < 1 || OPT_READ_CYCLES > `HSC_OPT_MAX_CYC
      || OPT_READ_CYCLES > 65535) begin : g_chk_opt
    $error("hsc_top: OPT_READ_CYCLES out of range");
  end
  // A wake load of one would leave the timer at zero and never finish
  if (`HSC_WAKE_VEC_CYC < `HSC_WAKE_VEC_MIN || `HSC_WAKE_VEC_CYC > `HSC_WAKE_VEC_MAX
      || `HSC_WAKE_VEC_CYC > 15) begin : g_chk_vec
    $error("hsc_top: vectored wake wait out of range");
  end
  if (`HSC_WAKE_PLAIN_CYC < `HSC_WAKE_PLAIN_MIN || `HSC_WAKE_PLAIN_CYC > `HSC_WAKE_PLAIN_MAX
      || `HSC_WAKE_PLAIN_CYC < 2) begin : g_chk_plain
    $error("hsc_top: plain wake wait out of range");
  end
  if (`HSC_CTRL_W != 6) begin : g_chk_ctrl
    $error("hsc_top: control field count must match the stored control bits");
  end

  localparam logic [15:0] OPT_LAST   = 16'(OPT_READ_CYCLES - 1);
  localparam logic [3:0]  WAKE_VEC   = 4'(`HSC_WAKE_VEC_CYC);
  localparam logic [3:0]  WAKE_PLAIN = 4'(`HSC_WAKE_PLAIN_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] pin_sync;
  logic       rst_pin_n;
  logic       strap_fixed;

  // Both pins clear to low: after a bus reset the option load also waits
  // out the two synchroniser stages before it starts counting
  hsc_sync2 #(
    .W       (2),
    .RST_VAL (2'h0)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({reset_pin_n_i, opt_lsosc_fixed_i}),
    .q_o   (pin_sync)
  );

  assign rst_pin_n   = pin_sync[1];
  assign strap_fixed = pin_sync[0];

  //////////////////////////////////////////////////////////////////////////////
  // Wake-up wait timer
  logic       wt_start;
  logic [3:0] wt_load;
  logic       wt_done;

  // Load of twelve or four, picked by the global enable at the wake edge
  hsc_wake_timer u_wake (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (wt_start),
    .load_i  (wt_load),
    .done_o  (wt_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic lsosc_running(input logic unstop, input logic [5:0] ctrl);
    lsosc_running = unstop | ~ctrl[`HSC_CTRL_LSOSC_STOP];
  endfunction

  function automatic logic [3:0] wake_len(input logic vec);
    wake_len = vec ? WAKE_VEC : WAKE_PLAIN;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State
  localparam hsc_top_s RST_S = '{
    st:          HSC_OPT,
    opt_cnt:     16'h0000,
    unstop:      1'b0,
    ctrl:        `HSC_CTRL_RST,
    last_vec:    1'b0,
    wake_irq:    1'b0,
    wdt_refused: 1'b0,
    pend_vec:    1'b0,
    ack:         1'b0,
    rdata:       32'h0000_0000,
    cpu_clk_en:  1'b0,
    rst_vec:     1'b0,
    vec_req:     1'b0,
    resume:      1'b0,
    halted:      1'b0,
    port_en:     1'b0,
    lsosc_en:    1'b0,
    tm16_en:     1'b0,
    tmb_en:      1'b0,
    wdt_en:      1'b0,
    aux_en:      1'b1
  };

  hsc_top_s s_ff;
  hsc_top_s nxt_s;

  logic             wb_req;
  logic             wb_wr;
  logic             ctrl_wr;
  logic             stat_wr;
  logic             halt_take;
  logic [IRQ_N-1:0] unmasked;
  logic             wake_pend;
  logic [5:0]       wr_ctrl;
  logic             run_on;
  logic             ls_run;
  logic [31:0]      status_word;
  logic [31:0]      pend_word;

  // No new hit while ack stands, so a held strobe is taken every other cycle
  assign wb_req    = wb_cyc_i & wb_stb_i & ~s_ff.ack;
  assign wb_wr     = wb_req & wb_we_i;
  assign ctrl_wr   = wb_wr & wb_sel_i[0] & (wb_adr_i == `HSC_OFS_CTRL);
  assign stat_wr   = wb_wr & wb_sel_i[0] & (wb_adr_i == `HSC_OFS_STATUS);
  assign halt_take = halt_exec_i & (s_ff.st == HSC_RUN);
  // Masked sources are ignored whatever the global enable says
  assign unmasked  = irq_req_i & ~interrupt_mask_flag_i;
  assign wake_pend = |unmasked;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`HSC_ST_STATE_LO +: 2] = s_ff.st;
    status_word[`HSC_ST_UNSTOP]        = s_ff.unstop;
    status_word[`HSC_ST_LAST_VEC]      = s_ff.last_vec;
    status_word[`HSC_ST_WAKE_IRQ]      = s_ff.wake_irq;
    status_word[`HSC_ST_WDT_REFUSED]   = s_ff.wdt_refused;
    pend_word = 32'h0000_0000;
    pend_word[IRQ_N-1:0] = unmasked;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.rst_vec = 1'b0;
    nxt_s.vec_req = 1'b0;
    nxt_s.resume  = 1'b0;
    nxt_s.ack     = wb_req;
    nxt_s.aux_en  = 1'b1;
    wt_start      = 1'b0;
    wt_load       = WAKE_PLAIN;
    wr_ctrl       = wb_dat_i[5:0];

    // Register reads answer one cycle after the request
    if (wb_req) begin
      case (wb_adr_i)
        `HSC_OFS_CTRL: begin
          nxt_s.rdata = {26'h000_0000, s_ff.ctrl};
        end
        `HSC_OFS_STATUS: begin
          nxt_s.rdata = status_word;
        end
        `HSC_OFS_PEND: begin
          nxt_s.rdata = pend_word;
        end
        default: begin
          nxt_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Status flag clear by writing one; a new refusal below wins
    if (stat_wr) begin
      if (wb_dat_i[`HSC_ST_WDT_REFUSED]) begin
        nxt_s.wdt_refused = 1'b0;
      end
      if (wb_dat_i[`HSC_ST_WAKE_IRQ]) begin
        nxt_s.wake_irq = 1'b0;
      end
    end

    if (ctrl_wr) begin
      if (s_ff.unstop && wr_ctrl[`HSC_CTRL_WDT_SYS]) begin
        wr_ctrl[`HSC_CTRL_WDT_SYS] = 1'b0;
        nxt_s.wdt_refused = 1'b1;
      end
      nxt_s.ctrl = wr_ctrl;
    end

    case (s_ff.st)
      HSC_OPT: begin
        // Core held stopped while the option configuration loads
        nxt_s.cpu_clk_en = 1'b0;
        // Strap sampled through the whole load; the last value sticks
        nxt_s.unstop     = strap_fixed;
        if (s_ff.opt_cnt == OPT_LAST) begin
          nxt_s.st         = HSC_RUN;
          nxt_s.opt_cnt    = 16'h0000;
          nxt_s.cpu_clk_en = 1'b1;
          nxt_s.rst_vec    = 1'b1;
          if (strap_fixed) begin
            nxt_s.ctrl[`HSC_CTRL_WDT_SYS] = 1'b0;
          end
        end else begin
          nxt_s.opt_cnt = s_ff.opt_cnt + 16'h0001;
        end
      end
      HSC_RUN: begin
        // Halt pulses outside RUN are dropped
        if (halt_take) begin
          nxt_s.cpu_clk_en = 1'b0;
          nxt_s.pend_vec   = global_interrupt_enable_i;
          if (wake_pend) begin
            // Request already pending: skip standby, go straight to wake
            nxt_s.st       = HSC_WAKE;
            nxt_s.wake_irq = 1'b1;
            wt_start       = 1'b1;
            wt_load        = wake_len(global_interrupt_enable_i);
          end else begin
            nxt_s.st = HSC_HALT;
          end
        end
      end
      HSC_HALT: begin
        nxt_s.cpu_clk_en = 1'b0;
        // Only an unmasked request leaves; the reset pin is handled below
        if (wake_pend) begin
          nxt_s.st       = HSC_WAKE;
          nxt_s.wake_irq = 1'b1;
          nxt_s.pend_vec = global_interrupt_enable_i;
          wt_start       = 1'b1;
          wt_load        = wake_len(global_interrupt_enable_i);
        end
      end
      HSC_WAKE: begin
        // Core stays gated until the wake timer ends
        nxt_s.cpu_clk_en = 1'b0;
        if (wt_done) begin
          nxt_s.st         = HSC_RUN;
          nxt_s.cpu_clk_en = 1'b1;
          nxt_s.last_vec   = s_ff.pend_vec;
          nxt_s.vec_req    = s_ff.pend_vec;
          nxt_s.resume     = ~s_ff.pend_vec;
        end
      end
      default: begin
        nxt_s.st = HSC_OPT;
      end
    endcase

    // Reset pin releases standby and restarts the option load
    if (!rst_pin_n) begin
      nxt_s.st         = HSC_OPT;
      nxt_s.opt_cnt    = 16'h0000;
      nxt_s.cpu_clk_en = 1'b0;
      nxt_s.vec_req    = 1'b0;
      nxt_s.resume     = 1'b0;
      nxt_s.rst_vec    = 1'b0;
      wt_start         = 1'b0;
    end

    // Peripheral enables follow the next state
    run_on        = (nxt_s.st != HSC_OPT);
    ls_run        = lsosc_running(nxt_s.unstop, nxt_s.ctrl);
    nxt_s.halted  = (nxt_s.st == HSC_HALT);
    // Port latches hold outside RUN, so standby keeps their last values
    nxt_s.port_en = (nxt_s.st == HSC_RUN);
    nxt_s.lsosc_en = run_on & ls_run;
    nxt_s.tm16_en = run_on & nxt_s.ctrl[`HSC_CTRL_TM16_ON];
    if (nxt_s.ctrl[`HSC_CTRL_TMB_LS]) begin
      nxt_s.tmb_en = run_on & nxt_s.ctrl[`HSC_CTRL_TMB_ON] & ls_run;
    end else begin
      nxt_s.tmb_en = run_on & nxt_s.ctrl[`HSC_CTRL_TMB_ON];
    end
    // A system-clock watchdog stops whenever the core clock is gated
    if (nxt_s.ctrl[`HSC_CTRL_WDT_SYS]) begin
      nxt_s.wdt_en = nxt_s.ctrl[`HSC_CTRL_WDT_ON] & (nxt_s.st == HSC_RUN);
    end else begin
      nxt_s.wdt_en = run_on & nxt_s.ctrl[`HSC_CTRL_WDT_ON] & ls_run;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= RST_S;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_dat_o               = s_ff.rdata;
  assign wb_ack_o               = s_ff.ack;
  assign cpu_clk_en_o           = s_ff.cpu_clk_en;
  assign reset_vector_o         = s_ff.rst_vec;
  assign vector_req_o           = s_ff.vec_req;
  assign resume_next_o          = s_ff.resume;
  assign halted_o               = s_ff.halted;
  assign port_latch_en_o        = s_ff.port_en;
  assign lsosc_en_o             = s_ff.lsosc_en;
  assign tm16_en_o              = s_ff.tm16_en;
  assign eight_bit_timer_b_en_o = s_ff.tmb_en;
  assign wdt_en_o               = s_ff.wdt_en;
  // Always-on monitors share one flop that stays set, reset included
  assign poc_en_o               = s_ff.aux_en;
  assign lvd_en_o               = s_ff.aux_en;
  assign extint_en_o            = s_ff.aux_en;
endmodule // hsc_top

/* testbench/hsc_top_assertions.sv */
`timescale 1ns/1ps
module hsc_top_assertions #(
  parameter int IRQ_N           = 8,
  parameter int OPT_READ_CYCLES = 13600
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             halt_exec_i,
  input wire logic [IRQ_N-1:0] irq_req_i,
  input wire logic [IRQ_N-1:0] interrupt_mask_flag_i,
  input wire logic             global_interrupt_enable_i,
  input wire logic             reset_pin_n_i,
  input wire logic             cpu_clk_en_o,
  input wire logic             reset_vector_o,
  input wire logic             vector_req_o,
  input wire logic             resume_next_o,
  input wire logic             halted_o,
  input wire logic             port_latch_en_o,
  input wire logic             lsosc_en_o,
  input wire logic             wdt_en_o,
  input wire logic             poc_en_o,
  input wire logic             lvd_en_o,
  input wire logic             extint_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        pend;
  logic        gie;
  logic [15:0] cnt_ff;
  logic        opt_ok;
  assign pend = |(irq_req_i & ~interrupt_mask_flag_i);
  assign gie  = global_interrupt_enable_i;
  assign opt_ok = cnt_ff >= OPT_READ_CYCLES && cnt_ff <= OPT_READ_CYCLES + 6;
  // Cycles since the last reset of either kind
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_pin_n_i) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff != 16'hFFFF) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  sequence s_plain;
    !cpu_clk_en_o [*5] ##1 (cpu_clk_en_o && resume_next_o && !vector_req_o);
  endsequence
  sequence s_vec;
    !cpu_clk_en_o ##12 !cpu_clk_en_o ##1 (cpu_clk_en_o && vector_req_o && !resume_next_o);
  endsequence
  sequence s_halt;
    halt_exec_i && cpu_clk_en_o && !halted_o && reset_pin_n_i;
  endsequence
  AST_ENTER: assert property (s_halt ##0 !pend |=> halted_o && !cpu_clk_en_o)
    else $error("halt not entered");
  AST_IMMEDIATE: assert property (s_halt ##0 pend |=> !halted_o ##[3:13] cpu_clk_en_o)
    else $error("pending request did not wake at once");
  AST_GATED: assert property (halted_o |-> !cpu_clk_en_o && !port_latch_en_o)
    else $error("clock or port latch active in halt");
  AST_WDT_HALT: assert property (halted_o && !lsosc_en_o |-> !wdt_en_o)
    else $error("watchdog runs in halt without oscillator");
  AST_PLAIN: assert property (halted_o && pend && !gie && reset_pin_n_i |-> s_plain)
    else $error("plain wake wrong");
  AST_VEC: assert property (halted_o && pend && gie && reset_pin_n_i |-> s_vec)
    else $error("vectored wake wrong");
  AST_MASKED: assert property (halted_o && !pend && reset_pin_n_i |=> halted_o)
    else $error("halt left without request");
  AST_PIN_RST: assert property (!reset_pin_n_i [*4] |-> !halted_o && !cpu_clk_en_o)
    else $error("reset pin ignored");
  AST_OPT: assert property (reset_vector_o |-> cpu_clk_en_o && opt_ok)
    else $error("option hold length wrong");
  AST_AUX: assert property (poc_en_o && lvd_en_o && extint_en_o)
    else $error("always-on block disabled");
endmodule // hsc_top_assertions

bind hsc_top hsc_top_assertions #(
  .IRQ_N(IRQ_N),
  .OPT_READ_CYCLES(OPT_READ_CYCLES)
) u_hsc_chk (
  .clk_i(clk_i), .rst_i(rst_i), .halt_exec_i(halt_exec_i), .irq_req_i(irq_req_i),
  .interrupt_mask_flag_i(interrupt_mask_flag_i),
  .global_interrupt_enable_i(global_interrupt_enable_i), .reset_pin_n_i(reset_pin_n_i),
  .cpu_clk_en_o(cpu_clk_en_o), .reset_vector_o(reset_vector_o), .vector_req_o(vector_req_o),
  .resume_next_o(resume_next_o), .halted_o(halted_o), .port_latch_en_o(port_latch_en_o),
  .lsosc_en_o(lsosc_en_o), .wdt_en_o(wdt_en_o), .poc_en_o(poc_en_o), .lvd_en_o(lvd_en_o),
  .extint_en_o(extint_en_o)
);

/* testbench/hsc_core_model.sv */
`timescale 1ns/1ps
module hsc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       halt_cmd_i,
  input  wire logic [7:0] irq_set_i,
  input  wire logic [7:0] irq_clr_i,
  input  wire logic       cpu_clk_en_i,
  input  wire logic       vector_req_i,
  output logic            halt_exec_o,
  output logic      [7:0] irq_req_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_exec_o <= 1'b0;
      irq_req_o   <= 8'h00;
    end else begin
      // Halt instruction only issues while the core clock runs
      halt_exec_o <= halt_cmd_i && cpu_clk_en_i && !halt_exec_o;
      // Vectored service acknowledges the pending flags
      irq_req_o   <= (irq_req_o | irq_set_i) & ~irq_clr_i & {8{!vector_req_i}};
    end
  end
endmodule // hsc_core_model

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import hsc_pkg::*;
  localparam int OPT = 20;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [3:0]  adr      = 4'h0;
  logic [31:0] wdat     = 32'h0;
  logic [3:0]  sel      = 4'hF;
  logic        halt_cmd = 1'b0;
  logic [7:0]  irq_set  = 8'h00;
  logic [7:0]  irq_clr  = 8'h00;
  logic [7:0]  mask     = 8'hFF;
  logic        gie      = 1'b0;
  logic        pin_n    = 1'b1;
  logic        fixed    = 1'b0;
  logic [31:0] rdat, rd;
  logic [7:0]  irq;
  logic        halt_ex, ack, clk_en, rvec, vreq, resume, halted, port_en;
  logic        ls_en, t16_en, tb_en, wdt_en;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          i, p, k, n, c, cs;
  int unsigned seed;

  always #20 clk_i = ~clk_i;

  hsc_top #(.IRQ_N(8), .OPT_READ_CYCLES(OPT)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .halt_exec_i(halt_ex), .irq_req_i(irq), .interrupt_mask_flag_i(mask),
    .global_interrupt_enable_i(gie), .reset_pin_n_i(pin_n), .opt_lsosc_fixed_i(fixed),
    .cpu_clk_en_o(clk_en), .reset_vector_o(rvec), .vector_req_o(vreq),
    .resume_next_o(resume), .halted_o(halted), .port_latch_en_o(port_en),
    .lsosc_en_o(ls_en), .tm16_en_o(t16_en), .eight_bit_timer_b_en_o(tb_en),
    .wdt_en_o(wdt_en), .poc_en_o(), .lvd_en_o(), .extint_en_o()
  );

  hsc_core_model u_core (
    .clk_i(clk_i), .rst_i(rst_i), .halt_cmd_i(halt_cmd), .irq_set_i(irq_set),
    .irq_clr_i(irq_clr), .cpu_clk_en_i(clk_en), .vector_req_i(vreq),
    .halt_exec_o(halt_ex), .irq_req_o(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int m;
    m = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      m++;
    end while (ack !== 1'b1 && m < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (m >= 50) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic wait_on(output int m);
    m = 0;
    while (clk_en !== 1'b1 && m < 2000) begin
      @(posedge clk_i);
      m++;
    end
    if (m >= 2000) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic halt_pulse();
    @(posedge clk_i);
    irq_set  <= 8'h00;
    halt_cmd <= 1'b1;
    @(posedge clk_i);
    halt_cmd <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic do_reset();
    int m;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_on(m);
    chk("reset_vector", rvec, 1'b1);
    chk("opt_hold", m >= OPT, 1'b1);
  endtask

  // Expected peripheral enables in halt: osc, 16-bit timer, timer B, watchdog
  function automatic logic [3:0] exp_en(input int cv, input int u);
    logic run;
    run = u[0] | !cv[0];
    return {run, cv[3], cv[4] & (cv[2] ? run : 1'b1), cv[5] & !cv[1] & run};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(18207);
    for (p = 0; p < 2; p++) begin
      fixed <= p[0];
      do_reset();
      wb(1'b0, 4'h0, 32'h0, rd);
      chk("ctrl_reset", rd, 32'h20);
      wb(1'b0, 4'hC, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      sel <= 4'hE;
      wb(1'b1, 4'h0, 32'h3F, rd);
      sel <= 4'hF;
      wb(1'b0, 4'h0, 32'h0, rd);
      chk("sel_ignored", rd, 32'h20);
      for (i = 0; i < 4; i++) begin
        gie <= i[0];
        c = ($urandom & 32'h3F) | (p << 1);
        cs = c & ~(p << 1);
        k = $urandom_range(7);
        wb(1'b1, 4'h0, c, rd);
        wb(1'b0, 4'h0, 32'h0, rd);
        chk("ctrl", rd, cs);
        irq_set <= 8'h01 << k;
        mask <= 8'hFF;
        halt_pulse();
        chk("halted", halted, 1'b1);
        chk("cpu_clk", clk_en, 1'b0);
        chk("port_latch", port_en, 1'b0);
        chk("enables", {ls_en, t16_en, tb_en, wdt_en}, exp_en(cs, p));
        wb(1'b0, 4'h8, 32'h0, rd);
        chk("pend", rd, 32'h0);
        chk("masked", halted, 1'b1);
        mask <= ~(8'h01 << k);
        wait_on(n);
        chk("vector", vreq, i[0]);
        chk("resume", resume, !i[0]);
        chk("wake_wait", n, i[0] ? 14 : 6);
        chk("port_run", port_en, 1'b1);
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("status", rd & 32'h3F, 17 + (i % 2) * 8 + p * 36);
        wb(1'b1, 4'h4, 32'h30, rd);
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("status_clr", rd & 32'h30, 32'h0);
        if (i[0] == 1'b0) begin
          halt_pulse();
          chk("wake_at_once", {halted, clk_en}, 2'b00);
          wait_on(n);
          chk("resume_at_once", resume, 1'b1);
        end
        irq_clr <= 8'hFF;
        @(posedge clk_i);
        irq_clr <= 8'h00;
      end
    end
    mask <= 8'hFF;
    halt_pulse();
    pin_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("pin_reset", {halted, clk_en}, 2'b00);
    pin_n <= 1'b1;
    wait_on(n);
    chk("pin_vector", rvec, 1'b1);
    summarize();
  end
endmodule // tb
